// ===== hw/sfc_pkg.sv
package sfc_pkg;

  // Frame widths
  localparam int OPC_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int BYTE_BITS = 8;
  localparam int HDR_BYTES = 4;

  // Address split, long (528-byte) pages
  localparam int LONG_PAGE_LSB = 10;
  localparam int LONG_ADDR_BITS = 22;
  // Address split, default (512-byte) pages
  localparam int SHORT_PAGE_LSB = 9;
  localparam int SHORT_ADDR_BITS = 21;
  localparam int PAGE_BITS = 12;
  // Sector number is the top of the page number
  localparam int SECT_LSB = 8;

  // Pin synchroniser slots
  localparam int PIN_CS = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_WP = 3;
  localparam int PIN_RST = 4;
  localparam int PIN_N = 5;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] RST_CNT = 5'h00;

  // Read opcodes aimed at the main array
  localparam logic [7:0] OP_RD_LEGACY = 8'hE8;
  localparam logic [7:0] OP_RD_FAST2 = 8'h1B;
  localparam logic [7:0] OP_RD_FAST1 = 8'h0B;
  localparam logic [7:0] OP_RD_SLOW = 8'h03;
  // Buffer reads, programs and erases
  localparam logic [7:0] OP_RD_BUF1 = 8'hD1;
  localparam logic [7:0] OP_RD_BUF2 = 8'hD3;
  localparam logic [7:0] OP_PROG_PAGE = 8'h82;
  localparam logic [7:0] OP_PROG_BYTES = 8'h02;
  localparam logic [7:0] OP_ERASE_PAGE = 8'h81;
  localparam logic [7:0] OP_ERASE_BLOCK = 8'h50;
  localparam logic [7:0] OP_ERASE_SECTOR = 8'h7C;
  localparam logic [7:0] OP_ERASE_CHIP = 8'hC7;

  // Command classes reported to the core
  typedef enum logic [2:0] {
    KIND_OTHER = 3'h0,
    KIND_RD_ARRAY = 3'h1,
    KIND_RD_BUF1 = 3'h2,
    KIND_RD_BUF2 = 3'h3,
    KIND_PROG = 3'h4,
    KIND_ERASE = 3'h5,
    KIND_ERASE_CHIP = 3'h6
  } sfc_kind_e;

  function automatic sfc_kind_e classify(input logic [7:0] op);
    sfc_kind_e k;
    k = KIND_OTHER;
    case (op)
      OP_RD_LEGACY, OP_RD_FAST2, OP_RD_FAST1, OP_RD_SLOW: k = KIND_RD_ARRAY;
      OP_RD_BUF1: k = KIND_RD_BUF1;
      OP_RD_BUF2: k = KIND_RD_BUF2;
      OP_PROG_PAGE, OP_PROG_BYTES: k = KIND_PROG;
      OP_ERASE_PAGE, OP_ERASE_BLOCK, OP_ERASE_SECTOR: k = KIND_ERASE;
      OP_ERASE_CHIP: k = KIND_ERASE_CHIP;
      default: k = KIND_OTHER;
    endcase
    return k;
  endfunction

  // Program or erase of any kind
  function automatic logic alters_array(input sfc_kind_e k);
    return (k == KIND_PROG) || (k == KIND_ERASE) || (k == KIND_ERASE_CHIP);
  endfunction

endpackage

// ===== hw/sfc_spi_if.sv
`timescale 1ns/100ps
interface sfc_spi_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic wp_n;
  logic reset_n;

  modport dev (
    input cs_n,
    input sck,
    input si,
    input wp_n,
    input reset_n,
    output so,
    output so_oe
  );

  modport host (
    output cs_n,
    output sck,
    output si,
    output wp_n,
    output reset_n,
    input so
  );
endinterface

// ===== hw/sfc_device.sv
// Operation
// - WP low blocks writes to locked sectors
// - WP low freezes the sector lock map
// - Protected program/erase opcode discarded, no activity
// - Discarded command ends at select rise: idle if busy is low, else waits for busy
// - Reset pin low aborts and forces idle
// - Select fall, then opcode, then address
// - Host clocks opcode and address in while selected
// - Everything shifts most significant bit first
// - Three address bytes, don't-care bits lead
// - Long pages: 12-bit page, 10-bit byte
// - Default pages: bits 20-9 page, 8-0 byte
// - Buffer index 10 bits long, 9 short
// - Page/byte program; chip/sector/block/page erase
// - Reads target array or either buffer
// - Sample on SCK rise, drive on fall
// - Deselected: ignore input, output released
// - Select rise ends; standby waits for busy
`timescale 1ns/100ps
module sfc_device #(
  parameter int NSECT = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Serial link
  sfc_spi_if.dev spi,
  // Configuration and array core status
  input wire logic page_528,
  input wire logic lock_wr,
  input wire logic [NSECT-1:0] lock_data,
  input wire logic busy,
  input wire logic [7:0] rd_data,
  // Decoded command
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [2:0] cmd_kind,
  output logic [11:0] page_number_bits,
  output logic [9:0] byte_in_page_bits,
  output logic [9:0] buffer_byte_index_long,
  output logic [8:0] buffer_byte_index_short,
  output logic [20:0] linear_array_address,
  // Data stream
  output logic din_valid,
  output logic [7:0] din_data,
  output logic rd_next,
  // Status
  output logic cmd_end,
  output logic cmd_refused,
  output logic abort,
  output logic idle,
  output logic [NSECT-1:0] lock_map
);

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_OPC = 6'b000010,
    ST_ADDR = 6'b000100,
    ST_DATA = 6'b001000,
    ST_DISCARD = 6'b010000,
    ST_WAIT = 6'b100000
  } sfc_dst_e;

  typedef struct packed {
    logic [sfc_pkg::PIN_N-1:0] s1;
    logic [sfc_pkg::PIN_N-1:0] s2;
    logic sck_d;
    logic cs_d;
    sfc_dst_e st;
    logic [4:0] cnt;
    logic [2:0] ocnt;
    logic [23:0] sh;
    logic [7:0] out;
    logic reading;
    logic so;
    logic so_oe;
    logic cmd_valid;
    logic [7:0] opcode;
    sfc_pkg::sfc_kind_e kind;
    logic [11:0] page;
    logic [9:0] byte_ix;
    logic [9:0] buf_long;
    logic [8:0] buf_short;
    logic [20:0] linear;
    logic din_valid;
    logic [7:0] din;
    logic rd_next;
    logic cmd_end;
    logic refused;
    logic abort;
    logic idle;
    logic [NSECT-1:0] lock;
  } sfc_dev_s;

  sfc_dev_s r;
  sfc_dev_s n;

  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  logic wp_low;
  logic [23:0] addr_full;
  logic [11:0] page_dec;
  logic [NSECT-1:0] sect_hit;

  // Edges only look at the second synchroniser stage
  assign sck_rise = r.s2[sfc_pkg::PIN_SCK] & ~r.sck_d;
  assign sck_fall = ~r.s2[sfc_pkg::PIN_SCK] & r.sck_d;
  assign cs_rise = r.s2[sfc_pkg::PIN_CS] & ~r.cs_d;
  assign cs_fall = ~r.s2[sfc_pkg::PIN_CS] & r.cs_d;
  assign wp_low = ~r.s2[sfc_pkg::PIN_WP];
  assign addr_full = {r.sh[22:0], r.s2[sfc_pkg::PIN_SI]};

  // Page field for the sector check, per page size
  assign page_dec = page_528 ?
    addr_full[sfc_pkg::LONG_PAGE_LSB +: sfc_pkg::PAGE_BITS] :
    addr_full[sfc_pkg::SHORT_PAGE_LSB +: sfc_pkg::PAGE_BITS];

  // One-hot sector select; chip erase touches every sector
  always_comb
  begin
    sect_hit = '0;
    if (r.kind == sfc_pkg::KIND_ERASE_CHIP)
    begin
      sect_hit = '1;
    end
    else
    begin
      sect_hit[page_dec[11:sfc_pkg::SECT_LSB]] = 1'b1;
    end
  end

  // Next state
  always_comb
  begin
    n = r;
    n.s1 = {spi.reset_n, spi.wp_n, spi.si, spi.sck, spi.cs_n};
    n.s2 = r.s1;
    n.sck_d = r.s2[sfc_pkg::PIN_SCK];
    n.cs_d = r.s2[sfc_pkg::PIN_CS];
    n.cmd_valid = 1'b0;
    n.din_valid = 1'b0;
    n.rd_next = 1'b0;
    n.cmd_end = 1'b0;
    n.refused = 1'b0;
    n.abort = 1'b0;
    // Lock map writes only while the pin is high
    if (lock_wr && !wp_low)
    begin
      n.lock = lock_data;
    end
    if (!r.s2[sfc_pkg::PIN_RST])
    begin
      // Held here for as long as the pin stays low
      n.st = ST_IDLE;
      n.so_oe = 1'b0;
      n.reading = 1'b0;
      n.abort = (r.st != ST_IDLE);
    end
    else if (cs_rise && r.st != ST_IDLE && r.st != ST_WAIT)
    begin
      // Select rise ends any frame, discarded or not
      n.so_oe = 1'b0;
      n.reading = 1'b0;
      n.cmd_end = 1'b1;
      n.st = busy ? ST_WAIT : ST_IDLE;
    end
    else
    begin
      unique case (r.st)
        ST_IDLE:
        begin
          if (cs_fall)
          begin
            n.st = ST_OPC;
            n.cnt = sfc_pkg::RST_CNT;
          end
        end
        ST_OPC:
        begin
          if (sck_rise)
          begin
            n.sh = {r.sh[22:0], r.s2[sfc_pkg::PIN_SI]};
            n.cnt = r.cnt + 5'h01;
            if (r.cnt == 5'(sfc_pkg::OPC_BITS - 1))
            begin
              n.opcode = {r.sh[6:0], r.s2[sfc_pkg::PIN_SI]};
              n.kind = sfc_pkg::classify(n.opcode);
              n.cnt = sfc_pkg::RST_CNT;
              if (wp_low && sfc_pkg::alters_array(n.kind))
              begin
                n.st = ST_DISCARD;
                n.refused = 1'b1;
              end
              else
              begin
                n.st = ST_ADDR;
              end
            end
          end
        end
        ST_ADDR:
        begin
          if (sck_rise)
          begin
            n.sh = addr_full;
            n.cnt = r.cnt + 5'h01;
            if (r.cnt == 5'(sfc_pkg::ADDR_BITS - 1))
            begin
              n.cnt = sfc_pkg::RST_CNT;
              // Pin may have dropped since the opcode
              if (wp_low && sfc_pkg::alters_array(r.kind) && |(sect_hit & r.lock))
              begin
                n.st = ST_DISCARD;
                n.refused = 1'b1;
              end
              else
              begin
                n.st = ST_DATA;
                n.cmd_valid = 1'b1;
                n.page = page_dec;
                // Leading bits are don't-care, address sits at the bottom
                n.byte_ix = page_528 ? addr_full[9:0] : {1'b0, addr_full[8:0]};
                n.buf_long = addr_full[9:0];
                n.buf_short = addr_full[8:0];
                n.linear = addr_full[sfc_pkg::SHORT_ADDR_BITS-1:0];
                n.reading = (r.kind == sfc_pkg::KIND_RD_ARRAY) ||
                  (r.kind == sfc_pkg::KIND_RD_BUF1) ||
                  (r.kind == sfc_pkg::KIND_RD_BUF2);
                n.out = rd_data;
                n.ocnt = 3'h0;
                n.rd_next = 1'b1;
              end
            end
          end
        end
        ST_DATA:
        begin
          // Incoming data bytes, MSB first
          if (sck_rise)
          begin
            n.din = {r.din[6:0], r.s2[sfc_pkg::PIN_SI]};
            n.cnt = r.cnt + 5'h01;
            if (r.cnt == 5'(sfc_pkg::BYTE_BITS - 1))
            begin
              n.din_valid = 1'b1;
              n.cnt = sfc_pkg::RST_CNT;
            end
          end
          // Outgoing bits change on the falling edge only
          if (sck_fall && r.reading)
          begin
            n.so = r.out[7];
            n.so_oe = 1'b1;
            n.ocnt = r.ocnt + 3'h1;
            if (r.ocnt == 3'h7)
            begin
              n.out = rd_data;
              n.rd_next = 1'b1;
            end
            else
            begin
              n.out = {r.out[6:0], 1'b0};
            end
          end
        end
        ST_DISCARD:
        begin
          // Nothing reaches the core; wait for select rise
          n.st = ST_DISCARD;
        end
        ST_WAIT:
        begin
          if (!busy)
          begin
            n.st = ST_IDLE;
          end
        end
      endcase
    end
    n.idle = (n.st == ST_IDLE);
  end

  // State register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      // Pin stages start at idle levels (clock and data low) so no false edge follows reset
      r <= '{s1: 5'h19, s2: 5'h19, sck_d: 1'b0, cs_d: 1'b1, st: ST_IDLE,
        cnt: sfc_pkg::RST_CNT, ocnt: 3'h0, sh: 24'h000000,
        out: sfc_pkg::RST_BYTE, reading: 1'b0, so: 1'b0, so_oe: 1'b0,
        cmd_valid: 1'b0, opcode: sfc_pkg::RST_BYTE, kind: sfc_pkg::KIND_OTHER,
        page: 12'h000, byte_ix: 10'h000, buf_long: 10'h000, buf_short: 9'h000,
        linear: 21'h000000, din_valid: 1'b0, din: sfc_pkg::RST_BYTE,
        rd_next: 1'b0, cmd_end: 1'b0, refused: 1'b0, abort: 1'b0, idle: 1'b1,
        lock: '0};
    end
    else
    begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign spi.so = r.so;
  assign spi.so_oe = r.so_oe;
  assign cmd_valid = r.cmd_valid;
  assign cmd_opcode = r.opcode;
  assign cmd_kind = r.kind;
  assign page_number_bits = r.page;
  assign byte_in_page_bits = r.byte_ix;
  assign buffer_byte_index_long = r.buf_long;
  assign buffer_byte_index_short = r.buf_short;
  assign linear_array_address = r.linear;
  assign din_valid = r.din_valid;
  assign din_data = r.din;
  assign rd_next = r.rd_next;
  assign cmd_end = r.cmd_end;
  assign cmd_refused = r.refused;
  assign abort = r.abort;
  assign idle = r.idle;
  assign lock_map = r.lock;

endmodule

// ===== hw/sfc_host.sv
`timescale 1ns/100ps
module sfc_host #(
  parameter int HALF = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Serial link
  sfc_spi_if.host spi,
  // Pin levels requested by the user
  input wire logic wp_level,
  input wire logic reset_level,
  // Command request
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [23:0] addr,
  input wire logic [15:0] nbytes,
  input wire logic [7:0] tx_data,
  // Answers
  output logic busy,
  output logic tx_take,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic done
);

  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001,
    HS_LOW = 5'b00010,
    HS_HIGH = 5'b00100,
    HS_END = 5'b01000,
    HS_GAP = 5'b10000
  } sfc_hst_e;

  typedef struct packed {
    logic s1;
    logic s2;
    sfc_hst_e st;
    logic [7:0] div;
    logic [2:0] bitn;
    logic [16:0] left;
    logic [16:0] idx;
    logic [23:0] hdr;
    logic [7:0] sh;
    logic [7:0] rxs;
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
    logic reset_n;
    logic busy;
    logic tx_take;
    logic rx_valid;
    logic [7:0] rx;
    logic done;
  } sfc_host_s;

  sfc_host_s r;
  sfc_host_s n;
  logic tick;
  logic [7:0] nxt_byte;

  // Half-period enable; must outlast both synchronisers
  assign tick = (r.div == 8'(HALF - 1));
  // Address bytes first, then user data
  assign nxt_byte = (r.idx < 17'(sfc_pkg::HDR_BYTES - 1)) ? r.hdr[23:16] : tx_data;

  always_comb
  begin
    n = r;
    n.s1 = spi.so;
    n.s2 = r.s1;
    n.wp_n = wp_level;
    n.reset_n = reset_level;
    n.tx_take = 1'b0;
    n.rx_valid = 1'b0;
    n.done = 1'b0;
    n.div = tick ? 8'h00 : r.div + 8'h01;
    unique case (r.st)
      HS_IDLE:
      begin
        n.div = 8'h00;
        if (start)
        begin
          // Select falls, first opcode bit on the line (mode 0)
          n.cs_n = 1'b0;
          n.sck = 1'b0;
          n.sh = opcode;
          n.si = opcode[7];
          n.hdr = addr;
          n.idx = 17'h00000;
          n.left = 17'(sfc_pkg::HDR_BYTES) + {1'b0, nbytes};
          n.bitn = 3'h0;
          n.busy = 1'b1;
          n.st = HS_LOW;
        end
      end
      HS_LOW:
      begin
        if (tick)
        begin
          n.sck = 1'b1;
          n.rxs = {r.rxs[6:0], r.s2};
          n.st = HS_HIGH;
        end
      end
      HS_HIGH:
      begin
        if (tick)
        begin
          n.sck = 1'b0;
          n.bitn = r.bitn + 3'h1;
          n.st = HS_LOW;
          if (r.bitn == 3'h7)
          begin
            n.idx = r.idx + 17'h00001;
            n.left = r.left - 17'h00001;
            if (r.idx >= 17'(sfc_pkg::HDR_BYTES))
            begin
              n.rx_valid = 1'b1;
              n.rx = r.rxs;
            end
            if (r.left == 17'h00001)
            begin
              n.st = HS_END;
            end
            else
            begin
              n.sh = nxt_byte;
              n.si = nxt_byte[7];
              n.hdr = {r.hdr[15:0], 8'h00};
              n.tx_take = (r.idx >= 17'(sfc_pkg::HDR_BYTES - 1));
            end
          end
          else
          begin
            n.sh = {r.sh[6:0], 1'b0};
            n.si = r.sh[6];
          end
        end
      end
      HS_END:
      begin
        if (tick)
        begin
          n.cs_n = 1'b1;
          n.st = HS_GAP;
        end
      end
      HS_GAP:
      begin
        if (tick)
        begin
          n.busy = 1'b0;
          n.done = 1'b1;
          n.st = HS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      r <= '{s1: 1'b0, s2: 1'b0, st: HS_IDLE, div: 8'h00, bitn: 3'h0,
        left: 17'h00000, idx: 17'h00000, hdr: 24'h000000, sh: 8'h00, rxs: 8'h00,
        cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1, reset_n: 1'b1, busy: 1'b0,
        tx_take: 1'b0, rx_valid: 1'b0, rx: 8'h00, done: 1'b0};
    end
    else
    begin
      r <= n;
    end
  end

  assign spi.cs_n = r.cs_n;
  assign spi.sck = r.sck;
  assign spi.si = r.si;
  assign spi.wp_n = r.wp_n;
  assign spi.reset_n = r.reset_n;
  assign busy = r.busy;
  assign tx_take = r.tx_take;
  assign rx_valid = r.rx_valid;
  assign rx_data = r.rx;
  assign done = r.done;

endmodule

// ===== tb/sfc_link_chk.sv
`timescale 1ns/100ps
module sfc_link_chk #(
  parameter int HALF = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Link wires
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic reset_n
);
  logic [7:0] hi_cnt_r;
  logic [7:0] hi_cnt_nxt;
  logic [7:0] rise_cnt_r;
  logic [7:0] rise_cnt_nxt;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // Length of each clock high phase, and clock rises seen inside a frame
  always_comb
  begin
    hi_cnt_nxt = sck ? hi_cnt_r + 8'h01 : 8'h00;
    rise_cnt_nxt = cs_n ? 8'h00 : rise_cnt_r + {7'h00, sck && (hi_cnt_r == 8'h00)};
  end

  // Cleared in reset so the first frame starts counting from zero
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      hi_cnt_r <= 8'h00;
      rise_cnt_r <= 8'h00;
    end
    else
    begin
      hi_cnt_r <= hi_cnt_nxt;
      rise_cnt_r <= rise_cnt_nxt;
    end
  end

  // Synchroniser delay allowed before the output lets go
  a_so_released: assert property (cs_n [*5] |-> !so_oe)
    else $error("serial out still enabled while deselected");
  a_reset_pin_quiet: assert property (!reset_n [*5] |-> !so_oe)
    else $error("serial out enabled while reset pin low");
  a_so_after_fall: assert property ($changed(so) && so_oe && $past(so_oe) |->
    !$past(sck) && !$past(sck, 2))
    else $error("serial out moved outside the clock low phase");
  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  a_select_leads: assert property ($fell(cs_n) |-> !sck [*8])
    else $error("clock rose too soon after select fell");
  a_si_held_rise: assert property ($rose(sck) |-> $stable(si) ##1 $stable(si))
    else $error("serial in moved at a clock rise");
  a_sck_half_high: assert property ($fell(sck) |-> hi_cnt_r == HALF)
    else $error("serial clock high phase of wrong length");
  a_oe_after_addr: assert property ($rose(so_oe) |-> rise_cnt_r >= 8'h20)
    else $error("output enabled before opcode and address ended");
endmodule

// ===== tb/serial_flash_cmd_frontend_tb.sv
`timescale 1ns/100ps
module serial_flash_cmd_frontend_tb;
  localparam int HALF = 8;
  localparam logic [23:0] A1 = 24'hE5A5C3;
  localparam logic [23:0] A2 = 24'hFD2B71;
  // User and core side stimulus, moved 1 ns after a rising edge
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic wp_level = 1'b1;
  logic reset_level = 1'b1;
  logic start = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [23:0] addr = 24'h000000;
  logic [7:0] tx_data = 8'h5A;
  logic page_528 = 1'b0;
  logic lock_wr = 1'b0;
  logic [15:0] lock_data = 16'h0000;
  logic busy = 1'b0;
  logic [7:0] rd_data = 8'h3C;
  // Design outputs
  logic h_busy, tx_take, rx_valid, done, cmd_valid, din_valid, rd_next;
  logic cmd_end, cmd_refused, abort, idle;
  logic [7:0] rx_data, cmd_opcode, din_data, rd0, tx0;
  logic [2:0] cmd_kind;
  logic [11:0] pg;
  logic [9:0] byt, bufl;
  logic [8:0] bufs;
  logic [20:0] lin;
  logic [15:0] lock_map;
  int error_cnt = 0;
  int check_count = 0;
  int n_cmd, n_ref, n_end, n_abort;
  logic [7:0] rx_q[$];
  logic [7:0] din_q[$];
  logic [7:0] ops [13] = '{8'hE8, 8'h1B, 8'h0B, 8'h03, sfc_pkg::OP_RD_BUF1,
    sfc_pkg::OP_RD_BUF2, sfc_pkg::OP_PROG_PAGE, sfc_pkg::OP_PROG_BYTES,
    sfc_pkg::OP_ERASE_PAGE, sfc_pkg::OP_ERASE_BLOCK, sfc_pkg::OP_ERASE_SECTOR,
    sfc_pkg::OP_ERASE_CHIP, 8'h9F};
  logic [2:0] kinds [13] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5,
    3'h5, 3'h6, 3'h0};

  sfc_spi_if spi_bus();
  sfc_host #(.HALF(HALF)) i_sfc_host (.clock(clock), .nrst(nrst), .spi(spi_bus),
    .wp_level(wp_level), .reset_level(reset_level), .start(start), .opcode(opcode),
    .addr(addr), .nbytes(16'h0002), .tx_data(tx_data), .busy(h_busy), .tx_take(tx_take),
    .rx_valid(rx_valid), .rx_data(rx_data), .done(done));
  sfc_device i_sfc_device (.clock(clock), .nrst(nrst), .spi(spi_bus), .page_528(page_528),
    .lock_wr(lock_wr), .lock_data(lock_data), .busy(busy), .rd_data(rd_data),
    .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_kind(cmd_kind),
    .page_number_bits(pg), .byte_in_page_bits(byt), .buffer_byte_index_long(bufl),
    .buffer_byte_index_short(bufs), .linear_array_address(lin), .din_valid(din_valid),
    .din_data(din_data), .rd_next(rd_next), .cmd_end(cmd_end), .cmd_refused(cmd_refused),
    .abort(abort), .idle(idle), .lock_map(lock_map));
  sfc_link_chk #(.HALF(HALF)) i_sfc_link_chk (.clock(clock), .nrst(nrst),
    .cs_n(spi_bus.cs_n), .sck(spi_bus.sck), .si(spi_bus.si), .so(spi_bus.so),
    .so_oe(spi_bus.so_oe), .reset_n(spi_bus.reset_n));

  always #2.5 clock = ~clock;

  // Core side feeds a new byte per take; monitors see pre-edge values
  always @(posedge clock)
  begin
    if (rd_next)
      rd_data <= #1 rd_data + 8'h11;
    if (tx_take)
      tx_data <= #1 tx_data + 8'h11;
    if (cmd_valid)
      rd0 = rd_data;
    if (rx_valid && n_cmd > 0)
      rx_q.push_back(rx_data);
    if (din_valid)
      din_q.push_back(din_data);
    n_cmd += cmd_valid;
    n_ref += cmd_refused;
    n_end += cmd_end;
    n_abort += abort;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One whole frame; the reset pin drops at cycle rst_at if it is reached
  task automatic run(input logic [7:0] op, input logic [23:0] a, input int rst_at);
    int i;
    n_cmd = 0;
    n_ref = 0;
    n_end = 0;
    n_abort = 0;
    rx_q.delete();
    din_q.delete();
    tx0 = tx_data;
    @(posedge clock);
    #1;
    opcode = op;
    addr = a;
    start = 1'b1;
    @(posedge clock);
    #1;
    start = 1'b0;
    for (i = 0; i < 2000; i++)
    begin
      @(posedge clock);
      #1;
      if (i == rst_at)
        reset_level = 1'b0;
      if (done)
        break;
    end
    if (i == 2000)
    begin
      error_cnt++;
      test_done();
    end
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic lock(input logic [15:0] d);
    @(posedge clock);
    #1;
    lock_data = d;
    lock_wr = 1'b1;
    @(posedge clock);
    #1;
    lock_wr = 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  initial
  begin
    repeat (10) @(posedge clock);
    #1;
    nrst = 1'b1;
    repeat (3) @(posedge clock);
    // Every opcode class, short pages, leading don't-care bits all set
    for (int k = 0; k < 13; k++)
    begin
      run(ops[k], A1, -1);
      chk(cmd_kind, kinds[k]);
      chk(h_busy, 0);
      chk(cmd_opcode, ops[k]);
      chk({pg, byt, bufs}, {A1[20:9], 1'b0, A1[8:0], A1[8:0]});
      chk(lin, A1[20:0]);
      if (k < 6)
        chk({rx_q[0], rx_q[1]}, {rd0, rd0 + 8'h11});
      if (k == 6)
        chk({din_q[0], din_q[1]}, {tx0, tx0 + 8'h11});
    end
    $display("test decode done");
    lock(16'hA50F);
    chk(lock_map, 16'hA50F);
    page_528 = 1'b1;
    run(8'h1B, A2, -1);
    chk({pg, byt, bufl}, {A2[21:10], A2[9:0], A2[9:0]});
    page_528 = 1'b0;
    $display("test long page done");
    // Protected program and erase are dropped, then idle at select rise
    wp_level = 1'b0;
    for (int k = 6; k < 12; k += 5)
    begin
      run(ops[k], A1, -1);
      chk({n_cmd[7:0], n_ref[7:0], n_end[7:0], 7'h00, idle}, 32'h00010101);
      chk(din_q.size(), 0);
    end
    lock(16'h1234);
    chk(lock_map, 16'hA50F);
    // Pin drops mid-address: only the lock map can refuse the locked sector
    wp_level = 1'b1;
    fork
      begin
        repeat (150) @(posedge clock);
        #1;
        wp_level = 1'b0;
      end
      run(sfc_pkg::OP_ERASE_SECTOR, A1, -1);
    join
    chk({n_cmd[7:0], n_ref[7:0], n_end[7:0], 7'h00, idle}, 32'h00010101);
    chk(din_q.size(), 0);
    wp_level = 1'b1;
    $display("test protect done");
    // Select rise during a self-timed operation waits for it
    busy = 1'b1;
    run(sfc_pkg::OP_PROG_BYTES, A1, -1);
    chk({n_end[7:0], 7'h00, idle}, 16'h0100);
    busy = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk(idle, 1);
    $display("test standby done");
    // Reset pin in mid-address aborts, then normal work resumes
    run(8'hE8, A1, 150);
    chk({n_cmd[7:0], n_abort[7:0], 7'h00, idle}, 24'h000101);
    reset_level = 1'b1;
    repeat (6) @(posedge clock);
    run(8'h0B, A1, -1);
    chk(n_cmd, 1);
    $display("test reset pin done");
    test_done();
  end
endmodule
